//--- plrc_defs.svh
// Constants of the power loss recovery controller: timing, clock and retained-store values.
// Assumes one 100 MHz clock and a synchronous active-high reset.
// What this block does
// (R1) The supervisor watches the standby rail in every state after shutdown or power loss.
// (R2) Standby stable for the whole 30 s observation means the system was switched off properly.
// (R3) Standby lost before the 30 s observation ends is classed as an AC power loss.
// (R4) A power loss is counted only when every supply, standby included, has gone.
// (R5) With the turn-on policy the system is switched on when standby returns after a loss.
// (R6) With the remain-off policy the system stays off when standby returns after a loss.
// (R7) With the last-state policy the system returns to the on or off state held before the loss.
// (R8) The 30 s observation runs only under the last-state policy.
// (R9) A loss within 30 s of a regular shutdown may leave the remembered state as on.
// (R10) Without a standby rail the policy is ignored and the system powers up when supplied.
// (R11) In the enhanced soft-off state only power button, sleep button and SMB alert wake it.
// (R12) Policy and remembered state sit in storage that survives total power loss.
`ifndef PLRC_DEFS_SVH
`define PLRC_DEFS_SVH

`define PLRC_CLK_HZ          64'd100000000
`define PLRC_OBSERVE_TIME_S  64'd30
`define PLRC_INIT_POLICY     2'h2
`define PLRC_INIT_LAST_ON    1'b0
`define PLRC_CNT_W           32

`endif

//--- plrc_pkg.sv
// Types of the power loss recovery controller.
// Assumes nothing beyond the constants header.
package plrc_pkg;

  typedef enum logic [1:0] {
    PLRC_POL_TURN_ON    = 2'h0,
    PLRC_POL_REMAIN_OFF = 2'h1,
    PLRC_POL_LAST_STATE = 2'h2
  } plrc_policy_t;

  // Gray codes along boot, on, observe, off, lost
  typedef enum logic [2:0] {
    PLRC_ST_BOOT    = 3'h0,
    PLRC_ST_ON      = 3'h1,
    PLRC_ST_OBSERVE = 3'h3,
    PLRC_ST_OFF     = 3'h2,
    PLRC_ST_LOST    = 3'h6
  } plrc_state_t;

  typedef struct packed {
    logic pwr_btn;
    logic sleep_btn;
    logic smb_alert;
    logic other;
  } plrc_wake_t;

  typedef struct packed {
    plrc_policy_t policy;
    logic         last_on;
  } plrc_nv_t;

endpackage

//--- plrc_nv_store.sv
// Retained store for restore policy and remembered on/off state.
// Assumes it sits on an always-alive domain: rst_i does not clear it, only nv_init_i.
`timescale 1ns/1ps
`include "plrc_defs.svh"

module plrc_nv_store (
  input  wire logic                clk_i,
  input  wire logic                nv_init_i,
  input  wire logic                pol_we_i,
  input  wire plrc_pkg::plrc_policy_t pol_i,
  input  wire logic                last_we_i,
  input  wire logic                last_i,
  output plrc_pkg::plrc_nv_t       nv_o
);

  plrc_pkg::plrc_nv_t nv_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Not on rst_i, so contents outlive a loss of every supply
  always_ff @(posedge clk_i)
  begin
    if (nv_init_i)
    begin
      nv_r.policy  <= plrc_pkg::plrc_policy_t'(`PLRC_INIT_POLICY);
      nv_r.last_on <= `PLRC_INIT_LAST_ON;
    end
    else
    begin
      if (pol_we_i)
      begin
        nv_r.policy <= pol_i; // R12
      end
      if (last_we_i)
      begin
        nv_r.last_on <= last_i; // R12
      end
    end
  end

  assign nv_o = nv_r;

endmodule // plrc_nv_store

//--- plrc_top.sv
// Power loss recovery controller: classifies shutdown versus AC loss and restores power.
// Assumes standby_ok_i, buttons and straps are synchronous to clk_i and debounced.
// rst_i is taken as the release of the controller when its own standby supply returns.
`timescale 1ns/1ps
`include "plrc_defs.svh"

module plrc_top #(
  parameter logic [`PLRC_CNT_W-1:0] OBSERVE_CYCLES =
    `PLRC_CNT_W'(`PLRC_OBSERVE_TIME_S * `PLRC_CLK_HZ)
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   standby_ok_i,
  input  wire logic                   standby_rail_i,
  input  wire logic                   shutdown_i,
  input  wire logic                   enh_soft_off_i,
  input  wire plrc_pkg::plrc_wake_t   wake_i,
  input  wire logic                   policy_we_i,
  input  wire plrc_pkg::plrc_policy_t policy_i,
  input  wire logic                   nv_init_i,
  output logic                        ps_on_o,
  output logic                        loss_event_o,
  output logic                        clean_off_o,
  output logic                        observing_o,
  output logic                        last_on_o,
  output plrc_pkg::plrc_policy_t      policy_o,
  output plrc_pkg::plrc_state_t       state_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  plrc_pkg::plrc_state_t    state_r;
  plrc_pkg::plrc_state_t    state_nxt;
  logic [`PLRC_CNT_W-1:0]   obs_cnt_r;
  logic [`PLRC_CNT_W-1:0]   obs_cnt_nxt;
  logic                     obs_done;
  logic                     ps_on_r;
  logic                     loss_r;
  logic                     loss_nxt;
  logic                     clean_r;
  logic                     clean_nxt;
  logic                     observing_r;
  logic                     last_we;
  logic                     last_d;
  logic                     wake_ok;
  plrc_pkg::plrc_nv_t       nv;

  ////////////////////////////////////////////////////////////////////////////////
  // Restore decision, used on first boot and after a loss

  function automatic logic restore_on(input plrc_pkg::plrc_nv_t nv_f,
                                      input logic rail_f);
    logic on_f;
    on_f = 1'b0;
    if (!rail_f)
    begin
      on_f = 1'b1; // R10
    end
    else
    begin
      unique case (nv_f.policy)
        plrc_pkg::PLRC_POL_TURN_ON:    on_f = 1'b1;        // R5
        plrc_pkg::PLRC_POL_REMAIN_OFF: on_f = 1'b0;        // R6
        plrc_pkg::PLRC_POL_LAST_STATE: on_f = nv_f.last_on; // R7
        // Unknown code written by software: safest is to stay off
        default:                       on_f = 1'b0;
      endcase
    end
    return on_f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Retained store

  plrc_nv_store u_nv (
    .clk_i     (clk_i),
    .nv_init_i (nv_init_i),
    .pol_we_i  (policy_we_i),
    .pol_i     (policy_i),
    .last_we_i (last_we),
    .last_i    (last_d),
    .nv_o      (nv)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Wake filter

  always_comb
  begin
    // Other sources are dropped while in the enhanced soft-off state
    wake_ok = wake_i.pwr_btn | wake_i.sleep_btn | wake_i.smb_alert
            | (wake_i.other & ~enh_soft_off_i); // R11
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Observation timer

  assign obs_done = (obs_cnt_r == OBSERVE_CYCLES - `PLRC_CNT_W'(1));

  always_comb
  begin
    obs_cnt_nxt = '0;
    if (state_r == plrc_pkg::PLRC_ST_OBSERVE && state_nxt == plrc_pkg::PLRC_ST_OBSERVE)
    begin
      obs_cnt_nxt = obs_cnt_r + `PLRC_CNT_W'(1); // R2
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      obs_cnt_r <= '0;
    end
    else
    begin
      obs_cnt_r <= obs_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb
  begin
    state_nxt = state_r;
    loss_nxt  = 1'b0;
    clean_nxt = 1'b0;
    last_we   = 1'b0;
    last_d    = 1'b0;
    unique case (state_r)
      plrc_pkg::PLRC_ST_BOOT, plrc_pkg::PLRC_ST_LOST:
      begin
        if (standby_ok_i)
        begin
          if (restore_on(nv, standby_rail_i))
          begin
            state_nxt = plrc_pkg::PLRC_ST_ON;
          end
          else
          begin
            state_nxt = plrc_pkg::PLRC_ST_OFF;
          end
        end
      end
      plrc_pkg::PLRC_ST_ON:
      begin
        // Remembered as on while running, so a loss here restores on under the last-state policy
        last_we = 1'b1;
        last_d  = 1'b1;
        if (!standby_ok_i)
        begin
          state_nxt = plrc_pkg::PLRC_ST_LOST; // R4
          loss_nxt  = 1'b1;
        end
        else if (shutdown_i)
        begin
          if (standby_rail_i && nv.policy == plrc_pkg::PLRC_POL_LAST_STATE)
          begin
            state_nxt = plrc_pkg::PLRC_ST_OBSERVE; // R8
          end
          else
          begin
            state_nxt = plrc_pkg::PLRC_ST_OFF;
            last_d    = 1'b0;
          end
        end
      end
      plrc_pkg::PLRC_ST_OBSERVE:
      begin
        // Remembered state still on until the interval completes
        if (!standby_ok_i)
        begin
          state_nxt = plrc_pkg::PLRC_ST_LOST; // R3 R9
          loss_nxt  = 1'b1;
        end
        else if (wake_ok)
        begin
          state_nxt = plrc_pkg::PLRC_ST_ON;
        end
        else if (obs_done)
        begin
          state_nxt = plrc_pkg::PLRC_ST_OFF; // R2
          clean_nxt = 1'b1;
          last_we   = 1'b1;
          last_d    = 1'b0;
        end
      end
      plrc_pkg::PLRC_ST_OFF:
      begin
        if (!standby_ok_i)
        begin
          state_nxt = plrc_pkg::PLRC_ST_LOST; // R1 R4
          loss_nxt  = 1'b1;
        end
        else if (wake_ok)
        begin
          state_nxt = plrc_pkg::PLRC_ST_ON;
        end
      end
      default:
      begin
        state_nxt = plrc_pkg::PLRC_ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= plrc_pkg::PLRC_ST_BOOT;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ps_on_r     <= 1'b0;
      observing_r <= 1'b0;
    end
    else
    begin
      ps_on_r     <= (state_nxt == plrc_pkg::PLRC_ST_ON);
      observing_r <= (state_nxt == plrc_pkg::PLRC_ST_OBSERVE);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loss_r  <= 1'b0;
      clean_r <= 1'b0;
    end
    else
    begin
      loss_r  <= loss_nxt;
      clean_r <= clean_nxt;
    end
  end

  assign ps_on_o      = ps_on_r;
  assign loss_event_o = loss_r;
  assign clean_off_o  = clean_r;
  assign observing_o  = observing_r;
  assign last_on_o    = nv.last_on;
  assign policy_o     = nv.policy;
  assign state_o      = state_r;

endmodule // plrc_top

//--- plrc_properties.sv
// Port assertions for plrc_top, bound at the foot.
// One clock domain; rst_i synchronous, active high.
`timescale 1ns/1ps
module plrc_properties #(parameter logic [31:0] OBSERVE_CYCLES = 32'h14) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_ok_i,
  input wire logic standby_rail_i,
  input wire logic shutdown_i,
  input wire logic enh_soft_off_i,
  input wire plrc_pkg::plrc_wake_t wake_i,
  input wire logic ps_on_o,
  input wire logic loss_event_o,
  input wire logic clean_off_o,
  input wire logic observing_o,
  input wire logic last_on_o,
  input wire plrc_pkg::plrc_policy_t policy_o,
  input wire plrc_pkg::plrc_state_t state_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire on = state_o == 3'h1;
  wire off = state_o == 3'h2;
  wire up = state_o == 3'h6 && standby_ok_i && standby_rail_i;
  wire go = on && shutdown_i && standby_ok_i;
  // Other sources are no wake event in enhanced soft-off
  wire wk = wake_i.pwr_btn | wake_i.sleep_btn | wake_i.smb_alert | wake_i.other & !enh_soft_off_i;
  // Consecutive samples with observing_o high
  logic [31:0] run_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !observing_o)
    begin
      run_r <= 32'h0;
    end
    else
    begin
      run_r <= run_r + 32'h1;
    end
  end
  property p_span; clean_off_o |-> run_r == OBSERVE_CYCLES; endproperty
  a_span: assert property (p_span) else $error("observe span wrong");
  property p_cut; observing_o |-> run_r < OBSERVE_CYCLES; endproperty
  a_cut: assert property (p_cut) else $error("observe overran");
  property p_loss; (on | off | state_o == 3'h3) & !standby_ok_i |=> loss_event_o & !ps_on_o;
  endproperty
  a_loss: assert property (p_loss) else $error("loss missed");
  property p_obs; go & standby_rail_i & policy_o == 2'h2 |=> observing_o; endproperty
  a_obs: assert property (p_obs) else $error("no observe");
  property p_skip; go & policy_o != 2'h2 |=> off & !observing_o & !last_on_o; endproperty
  a_skip: assert property (p_skip) else $error("observe not skipped");
  property p_clean; clean_off_o |-> off & !last_on_o & $past(observing_o); endproperty
  a_clean: assert property (p_clean) else $error("bad clean off");
  property p_turn; up & policy_o == 2'h0 |=> ps_on_o & on; endproperty
  a_turn: assert property (p_turn) else $error("not turned on");
  // Codes 1 and 3 both keep the system off
  property p_stay; up & policy_o[0] |=> !ps_on_o & off; endproperty
  a_stay: assert property (p_stay) else $error("not kept off");
  property p_last; up & policy_o == 2'h2 |=> ps_on_o == $past(last_on_o); endproperty
  a_last: assert property (p_last) else $error("last state lost");
  property p_wake; off & standby_ok_i |=> ps_on_o == $past(wk); endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
endmodule // plrc_properties

bind plrc_top plrc_properties #(.OBSERVE_CYCLES(OBSERVE_CYCLES)) u_props (.clk_i, .rst_i,
  .standby_ok_i, .standby_rail_i, .shutdown_i, .enh_soft_off_i, .wake_i, .ps_on_o,
  .loss_event_o, .clean_off_o, .observing_o, .last_on_o, .policy_o, .state_o);

//--- plrc_psu_model.sv
// Supply model: standby rail follows the mains level.
// Mains level comes from the bench at clock edges.
`timescale 1ns/1ps
module plrc_psu_model (
  input  wire logic clk_i,
  input  wire logic ac_i,
  output logic      standby_ok_o
);
  // Rail takes a cycle to settle after mains changes
  always_ff @(posedge clk_i) standby_ok_o <= ac_i;
endmodule // plrc_psu_model

//--- tb.sv
// Self-checking bench for plrc_top with a short observation count.
// Standby comes from plrc_psu_model, fed by the mains level set here.
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module tb;
  localparam logic [31:0] OBS = 32'h14;
  logic clk_i = 1'b0, rst_i = 1'b1, ac = 1'b1, standby_rail_i = 1'b1, shutdown_i = 1'b0;
  logic enh_soft_off_i = 1'b1, policy_we_i = 1'b0, nv_init_i = 1'b1, standby_ok_i, ps_on_o;
  logic loss_event_o, clean_off_o, observing_o, last_on_o, want;
  logic [1:0] p;
  plrc_pkg::plrc_wake_t wake_i = 4'h0;
  plrc_pkg::plrc_policy_t policy_i = plrc_pkg::PLRC_POL_TURN_ON, policy_o;
  plrc_pkg::plrc_state_t state_o;
  int err_total = 0, checks_done = 0, losses = 0, lb, k, seed = 24364, n;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) losses += loss_event_o === 1'b1;
  plrc_psu_model psu (.clk_i, .ac_i(ac), .standby_ok_o(standby_ok_i));
  plrc_top #(.OBSERVE_CYCLES(OBS)) dut (.clk_i, .rst_i, .standby_ok_i, .standby_rail_i,
    .shutdown_i, .enh_soft_off_i, .wake_i, .policy_we_i, .policy_i, .nv_init_i, .ps_on_o,
    .loss_event_o, .clean_off_o, .observing_o, .last_on_o, .policy_o, .state_o);
  task cy(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // Power state expected once standby returns after a loss
  function automatic logic exp_restore(input logic rail, input logic [1:0] pol,
                                       input logic was_on);
    return !rail || pol == 2'h0 || (pol == 2'h2 && was_on);
  endfunction
  // Held one cycle; looked at once the taking edge has settled
  task pulse(input logic s, input logic [3:0] w);
    cy(1);
    shutdown_i <= s;
    wake_i <= w;
    cy(1);
    shutdown_i <= 1'b0;
    wake_i <= 4'h0;
    #1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    cy(20000);
    err_total++;
    results;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cy(10);
    rst_i <= 1'b0;
    nv_init_i <= 1'b0;
    cy(2);
    #1;
    `CHK("policy", 2'h2, policy_o)
    `CHK("boot", 1'b0, ps_on_o)
    for (n = 0; n < 4; n++)
    begin
      pulse(1'b0, 4'h1 << n);
      `CHK("wake", n != 0, ps_on_o)
      if (n != 0)
      begin
        lb = losses;
        pulse(1'b1, 4'h0);
        for (k = 0; observing_o === 1'b1 && k < 99; k++)
        begin
          cy(1);
          #1;
        end
        `CHK("observe", OBS, k)
        `CHK("clean", 1'b1, clean_off_o)
        `CHK("no loss", lb, losses)
        `CHK("last off", 1'b0, last_on_o)
      end
    end
    // Other sources count again once out of the enhanced soft-off state
    cy(1);
    enh_soft_off_i <= 1'b0;
    pulse(1'b0, 4'h1);
    `CHK("wake other", 1'b1, ps_on_o)
    $display("wake and observe test done");
    for (n = 0; n < 24; n++)
    begin
      p = 2'($random(seed));
      want = 1'($random(seed));
      cy(1);
      policy_we_i <= 1'b1;
      policy_i <= plrc_pkg::plrc_policy_t'(p);
      standby_rail_i <= 2'($random(seed)) != 2'h0;
      enh_soft_off_i <= 1'($random(seed));
      cy(1);
      policy_we_i <= 1'b0;
      #1;
      if (ps_on_o !== want)
        pulse(!want, {want, 3'h0});
      // Let a clean shutdown finish, or cut mains mid-observation
      if (!want)
        cy(OBS);
      else if (1'($random(seed)))
        pulse(1'b1, 4'h0);
      cy(1);
      ac <= 1'b0;
      cy(2);
      #1;
      `CHK("loss", 1'b1, loss_event_o)
      cy(1);
      rst_i <= n % 4 == 1;
      cy(2);
      rst_i <= 1'b0;
      ac <= 1'b1;
      cy(2);
      #1;
      `CHK("kept", p, policy_o)
      `CHK("restore", exp_restore(standby_rail_i, p, want), ps_on_o)
    end
    $display("restore test done");
    results;
  end
endmodule // tb
